// >>> src/gdcfg_pkg.sv
package gdcfg_pkg;
    // Register addresses on the serial register port
    localparam logic [5:0] ADDR_MAIN = 6'h02;
    localparam logic [5:0] ADDR_DRIVE = 6'h03;
    localparam logic [5:0] ADDR_OCMON = 6'h04;
    localparam logic [5:0] ADDR_CHOP = 6'h05;

    // Reset values
    localparam logic [7:0] DRIVE_RESET = 8'h07;
    localparam logic [7:0] OCMON_RESET = 8'h70;
    localparam logic [7:0] CHOP_RESET = 8'h01;
    localparam logic [7:0] MAIN_RESET = 8'h18;

    // Settings lock keys in main control bits 5-3
    localparam logic [2:0] LOCK_KEY = 3'h6;
    localparam logic [2:0] UNLOCK_KEY = 3'h3;
    localparam int LOCK_LSB = 3;

    // Writable masks; reserved bits 3-2 of the monitor register stay zero
    localparam logic [7:0] OCMON_WMASK = 8'hf3;

    // Watchdog timeouts
    localparam int CLK_MHZ = 100;
    localparam int WD_T0_MS = 10;
    localparam int WD_T1_MS = 20;
    localparam int WD_T2_MS = 50;
    localparam int WD_T3_MS = 100;
    localparam int WD_CYC0 = WD_T0_MS * 1000 * CLK_MHZ;
    localparam int WD_CYC1 = WD_T1_MS * 1000 * CLK_MHZ;
    localparam int WD_CYC2 = WD_T2_MS * 1000 * CLK_MHZ;
    localparam int WD_CYC3 = WD_T3_MS * 1000 * CLK_MHZ;
    localparam int WD_W = 24;

    typedef struct packed {
        logic [1:0] gate_gap_select;
        logic timeout_monitor_enable;
        logic [1:0] timeout_period_select;
        logic [2:0] gate_current_strength;
    } gdcfg_drive_t;

    typedef struct packed {
        logic amp_output_clamp;
        logic [2:0] drain_source_threshold;
        logic [1:0] reserved;
        logic high_fet_monitor_disable;
        logic low_fet_monitor_disable;
    } gdcfg_ocmon_t;

    typedef struct packed {
        logic [1:0] chop_blank_period;
        logic regulation_disable;
        logic [1:0] ref_scale;
        logic sample_hold_enable;
        logic [1:0] amp_gain;
    } gdcfg_chop_t;
endpackage : gdcfg_pkg

// >>> src/gdcfg_watchdog.sv
module gdcfg_watchdog
    import gdcfg_pkg::*;
#(
    parameter int CYC0 = WD_CYC0,
    parameter int CYC1 = WD_CYC1,
    parameter int CYC2 = WD_CYC2,
    parameter int CYC3 = WD_CYC3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic [1:0] period,
    input wire logic kick,
    output logic expired
);
    logic [WD_W-1:0] count;
    logic [WD_W-1:0] limit;

    // Timeout selection
    always_comb begin
        unique case (period)
            2'h0: limit = WD_W'(CYC0 - 1);
            2'h1: limit = WD_W'(CYC1 - 1);
            2'h2: limit = WD_W'(CYC2 - 1);
            default: limit = WD_W'(CYC3 - 1);
        endcase
    end

    // Counter runs only while armed; a kick restarts it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
            expired <= 1'b0;
        end else if (!enable || kick) begin
            count <= '0;
            expired <= 1'b0;
        end else if (count >= limit) begin
            expired <= 1'b1; // Held until kick or disable
        end else begin
            count <= count + WD_W'(1);
        end
    end
endmodule : gdcfg_watchdog

// >>> src/gdcfg_regs.sv
module gdcfg_regs
    import gdcfg_pkg::*;
#(
    parameter int WD_CYCLES0 = WD_CYC0,
    parameter int WD_CYCLES1 = WD_CYC1,
    parameter int WD_CYCLES2 = WD_CYC2,
    parameter int WD_CYCLES3 = WD_CYC3
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [5:0] ADDR,
    input wire logic [7:0] WDATA,
    output logic [7:0] RDATA,
    output logic LOCKED,
    output gdcfg_drive_t DRIVE_CFG,
    output gdcfg_ocmon_t OCMON_CFG,
    output gdcfg_chop_t CHOP_CFG,
    output logic HIGH_MON_EN,
    output logic LOW_MON_EN,
    output logic WD_EXPIRED
);
    logic [2:0] lock_field;
    logic wr_main;
    logic wr_cfg;
    logic [2:0] key;
    logic wd_expired;
    logic [7:0] next_rdata;

    assign key = WDATA[LOCK_LSB +: 3];
    assign wr_main = WR_EN && (ADDR == ADDR_MAIN);
    assign wr_cfg = WR_EN && !LOCKED;

    // Lock state and its visible field; only the two keys change it
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            LOCKED <= 1'b0;
            lock_field <= MAIN_RESET[LOCK_LSB +: 3];
        end else if (wr_main) begin
            if (!LOCKED && key == LOCK_KEY) begin
                LOCKED <= 1'b1;
                lock_field <= key;
            end else if (LOCKED && key == UNLOCK_KEY) begin
                LOCKED <= 1'b0;
                lock_field <= key;
            end
        end
    end

    // Drive register: dead time, watchdog, gate current
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            DRIVE_CFG <= DRIVE_RESET;
        end else if (wr_cfg && ADDR == ADDR_DRIVE) begin
            DRIVE_CFG <= WDATA;
        end
    end

    // Overcurrent monitor register; reserved bits masked
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            OCMON_CFG <= OCMON_RESET;
        end else if (wr_cfg && ADDR == ADDR_OCMON) begin
            OCMON_CFG <= WDATA & OCMON_WMASK;
        end
    end

    // Chopping and amplifier register
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            CHOP_CFG <= CHOP_RESET;
        end else if (wr_cfg && ADDR == ADDR_CHOP) begin
            CHOP_CFG <= WDATA;
        end
    end

    // Per-FET monitor enables registered from the disable bits
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            HIGH_MON_EN <= 1'b1;
            LOW_MON_EN <= 1'b1;
        end else begin
            HIGH_MON_EN <= !OCMON_CFG.high_fet_monitor_disable;
            LOW_MON_EN <= !OCMON_CFG.low_fet_monitor_disable;
        end
    end

    // Any register access counts as a watchdog service
    gdcfg_watchdog #(
        .CYC0(WD_CYCLES0),
        .CYC1(WD_CYCLES1),
        .CYC2(WD_CYCLES2),
        .CYC3(WD_CYCLES3)
    ) u_wd (
        .clk(CLK),
        .rst(RST),
        .enable(DRIVE_CFG.timeout_monitor_enable),
        .period(DRIVE_CFG.timeout_period_select),
        .kick(WR_EN || RD_EN),
        .expired(wd_expired)
    );

    // Expiry flag re-registered so the output leaves straight from a flop
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            WD_EXPIRED <= 1'b0;
        end else begin
            WD_EXPIRED <= wd_expired;
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        next_rdata = 8'h00;
        unique case (ADDR)
            ADDR_MAIN: next_rdata = {2'h0, lock_field, 3'h0};
            ADDR_DRIVE: next_rdata = DRIVE_CFG;
            ADDR_OCMON: next_rdata = OCMON_CFG & OCMON_WMASK;
            ADDR_CHOP: next_rdata = CHOP_CFG;
            default: next_rdata = 8'h00;
        endcase
    end

    // Read data registered one cycle after the strobe
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            RDATA <= 8'h00;
        end else if (RD_EN) begin
            RDATA <= next_rdata;
        end
    end

    AST_LOCK_BLOCKS: assert property (@(posedge CLK) disable iff (RST)
        LOCKED && WR_EN && ADDR == ADDR_DRIVE |=> $stable(DRIVE_CFG))
        else $error("drive register changed while locked");
    AST_LOCK_SET: assert property (@(posedge CLK) disable iff (RST)
        !LOCKED && wr_main && key == LOCK_KEY |=> LOCKED)
        else $error("lock key did not lock");
    AST_UNLOCK: assert property (@(posedge CLK) disable iff (RST)
        LOCKED && wr_main && key != UNLOCK_KEY |=> LOCKED)
        else $error("wrong key unlocked");
    AST_RSV_ZERO: assert property (@(posedge CLK) disable iff (RST)
        OCMON_CFG.reserved == 2'h0)
        else $error("reserved bits set");
    AST_DRIVE_WR: assert property (@(posedge CLK) disable iff (RST)
        !LOCKED && WR_EN && ADDR == ADDR_DRIVE |=> DRIVE_CFG == $past(WDATA))
        else $error("drive write lost");
    AST_CHOP_WR: assert property (@(posedge CLK) disable iff (RST)
        !LOCKED && WR_EN && ADDR == ADDR_CHOP |=> CHOP_CFG == $past(WDATA))
        else $error("chop write lost");
    AST_HMON: assert property (@(posedge CLK) disable iff (RST)
        ##1 HIGH_MON_EN == !$past(OCMON_CFG.high_fet_monitor_disable))
        else $error("high monitor enable wrong");
    AST_LMON: assert property (@(posedge CLK) disable iff (RST)
        ##1 LOW_MON_EN == !$past(OCMON_CFG.low_fet_monitor_disable))
        else $error("low monitor enable wrong");
    AST_WD_OFF: assert property (@(posedge CLK) disable iff (RST)
        !DRIVE_CFG.timeout_monitor_enable [*3] |-> !WD_EXPIRED)
        else $error("watchdog fired while disabled");

    // Lock guards every configuration register, not just the drive one
    AST_LOCK_OCMON: assert property (@(posedge CLK) disable iff (RST)
        LOCKED && WR_EN && ADDR == ADDR_OCMON |=> $stable(OCMON_CFG))
        else $error("monitor register changed while locked");
    AST_LOCK_CHOP: assert property (@(posedge CLK) disable iff (RST)
        LOCKED && WR_EN && ADDR == ADDR_CHOP |=> $stable(CHOP_CFG))
        else $error("chop register changed while locked");
    AST_UNLOCK_KEY: assert property (@(posedge CLK) disable iff (RST)
        LOCKED && wr_main && key == UNLOCK_KEY |=> !LOCKED)
        else $error("unlock key did not unlock");
    AST_NO_FALSE_LOCK: assert property (@(posedge CLK) disable iff (RST)
        !LOCKED && wr_main && key != LOCK_KEY |=> !LOCKED)
        else $error("wrong key locked");
    AST_LOCK_HOLD: assert property (@(posedge CLK) disable iff (RST)
        LOCKED && !wr_main |=> LOCKED)
        else $error("lock dropped without a key");
    AST_FREE_HOLD: assert property (@(posedge CLK) disable iff (RST)
        !LOCKED && !wr_main |=> !LOCKED)
        else $error("lock set without a key");
    AST_OCMON_WR: assert property (@(posedge CLK) disable iff (RST)
        !LOCKED && WR_EN && ADDR == ADDR_OCMON |=> OCMON_CFG == ($past(WDATA) & OCMON_WMASK))
        else $error("monitor write lost");

    // Read port returns the drive and chop registers as they stood at the strobe; monitor reads check only that reserved bits are zero
    AST_RD_DRIVE: assert property (@(posedge CLK) disable iff (RST)
        RD_EN && ADDR == ADDR_DRIVE |=> RDATA == $past(DRIVE_CFG))
        else $error("drive readback wrong");
    AST_RD_OCMON: assert property (@(posedge CLK) disable iff (RST)
        RD_EN && ADDR == ADDR_OCMON |=> (RDATA & ~OCMON_WMASK) == 8'h00)
        else $error("reserved bits read non-zero");
    AST_RD_CHOP: assert property (@(posedge CLK) disable iff (RST)
        RD_EN && ADDR == ADDR_CHOP |=> RDATA == $past(CHOP_CFG))
        else $error("chop readback wrong");

    // Any access clears the expiry within two flops
    AST_WD_CLEAR: assert property (@(posedge CLK) disable iff (RST)
        WR_EN || RD_EN |=> ##1 !WD_EXPIRED)
        else $error("access did not clear the watchdog");

    COV_LOCK: cover property (@(posedge CLK) disable iff (RST) $rose(LOCKED));
    COV_UNLOCK: cover property (@(posedge CLK) disable iff (RST) $fell(LOCKED));
    COV_WD: cover property (@(posedge CLK) disable iff (RST) $rose(WD_EXPIRED));
    COV_LOCKED_WRITE: cover property (@(posedge CLK) disable iff (RST)
        LOCKED && WR_EN && ADDR != ADDR_MAIN);
    COV_MON_OFF: cover property (@(posedge CLK) disable iff (RST)
        !HIGH_MON_EN && !LOW_MON_EN);
endmodule : gdcfg_regs

// >>> sim/gdcfg_fet_model.sv
module gdcfg_fet_model (
    input wire logic clk,
    input wire logic high_mon_en,
    input wire logic low_mon_en,
    input wire logic over_current,
    output logic high_trip,
    output logic low_trip
);
    timeunit 1ns;
    timeprecision 1ps;
    // A FET whose monitor is switched off never reports a trip
    always_ff @(posedge clk) begin
        high_trip <= over_current & high_mon_en;
        low_trip <= over_current & low_mon_en;
    end
endmodule : gdcfg_fet_model

// >>> sim/gate_driver_config_registers_tb.sv
module gate_driver_config_registers_tb
    import gdcfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK, RST, WR_EN, RD_EN, LOCKED, HIGH_MON_EN, LOW_MON_EN, WD_EXPIRED;
    logic [5:0] ADDR, a;
    logic [7:0] WDATA, RDATA, d;
    logic [7:0] mir [3:5];
    gdcfg_drive_t DRIVE_CFG;
    gdcfg_ocmon_t OCMON_CFG;
    gdcfg_chop_t CHOP_CFG;
    logic oc, htrip, ltrip, ok;
    logic [31:0] seed;
    int err_count, num_checks, n;
    // Short watchdog counts keep the run brief
    gdcfg_regs #(.WD_CYCLES0(20), .WD_CYCLES1(30), .WD_CYCLES2(40), .WD_CYCLES3(50)) dut (
        .CLK(CLK), .RST(RST), .WR_EN(WR_EN), .RD_EN(RD_EN), .ADDR(ADDR), .WDATA(WDATA),
        .RDATA(RDATA), .LOCKED(LOCKED), .DRIVE_CFG(DRIVE_CFG), .OCMON_CFG(OCMON_CFG),
        .CHOP_CFG(CHOP_CFG), .HIGH_MON_EN(HIGH_MON_EN), .LOW_MON_EN(LOW_MON_EN),
        .WD_EXPIRED(WD_EXPIRED));
    gdcfg_fet_model fets (.clk(CLK), .high_mon_en(HIGH_MON_EN), .low_mon_en(LOW_MON_EN),
        .over_current(oc), .high_trip(htrip), .low_trip(ltrip));
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    // Reserved monitor bits never take a written one
    function automatic logic [7:0] mask(input logic [5:0] ad);
        return (ad == 6'h04) ? 8'hf3 : 8'hff;
    endfunction : mask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (e !== g) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [5:0] ad, input logic [7:0] v);
        @(posedge CLK);
        WR_EN <= 1'b1;
        ADDR <= ad;
        WDATA <= v;
        @(posedge CLK);
        WR_EN <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [5:0] ad, output logic [7:0] v);
        @(posedge CLK);
        RD_EN <= 1'b1;
        ADDR <= ad;
        @(posedge CLK);
        RD_EN <= 1'b0;
        #1;
        v = RDATA;
    endtask : rd
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        err_count = 0;
        num_checks = 0;
        seed = 32'hb6339d6b;
        RST = 1'b1;
        {WR_EN, RD_EN, ADDR, WDATA, oc} = '0;
        repeat (16) @(posedge CLK);
        RST <= 1'b0;
        #1;
        // Reset state of the three config registers, the monitor enables and the main register
        chk("drive", 8'h07, DRIVE_CFG);
        chk("ocmon", 8'h70, OCMON_CFG);
        chk("chop", 8'h01, CHOP_CFG);
        chk("mon_en", 8'h03, {6'h00, HIGH_MON_EN, LOW_MON_EN});
        rd(6'h02, d);
        chk("main", 8'h18, d);
        mir = '{8'h07, 8'h70, 8'h01};
        $display("test reset done");
        // Random writes with readback, reserved bits included
        for (int i = 0; i < 24; i++) begin
            seed = xs(seed);
            a = 6'h03 + 6'(seed[9:8] % 2'h3);
            wr(a, seed[7:0]);
            mir[a] = seed[7:0] & mask(a);
            rd(a, d);
            chk("readback", mir[a], d);
        end
        chk("drive_out", mir[3], DRIVE_CFG);
        chk("ocmon_out", mir[4], OCMON_CFG);
        chk("chop_out", mir[5], CHOP_CFG);
        rd(6'h3f, d);
        chk("unmapped", 8'h00, d);
        $display("test random done");
        // Each monitor disable combination, with the FETs overloaded
        @(posedge CLK);
        oc <= 1'b1;
        for (int v = 0; v < 4; v++) begin
            wr(6'h04, 8'h70 | 8'(v));
            mir[4] = 8'h70 | 8'(v);
            repeat (2) @(posedge CLK);
            #1;
            chk("mon_en", 8'(~v & 3), {6'h00, HIGH_MON_EN, LOW_MON_EN});
            chk("trip", 8'(~v & 3), {6'h00, htrip, ltrip});
        end
        $display("test monitors done");
        // Lock blocks writes; a wrong key neither locks nor unlocks
        wr(6'h02, 8'h28);
        chk("no_lock", 8'h00, {7'h00, LOCKED});
        wr(6'h02, 8'h30);
        chk("locked", 8'h01, {7'h00, LOCKED});
        rd(6'h02, d);
        chk("main_key", 8'h30, d);
        wr(6'h03, 8'hff);
        wr(6'h04, 8'hff);
        wr(6'h05, 8'hff);
        wr(6'h02, 8'h28);
        chk("drive_locked", mir[3], DRIVE_CFG);
        chk("ocmon_locked", mir[4], OCMON_CFG);
        chk("chop_locked", mir[5], CHOP_CFG);
        chk("still_locked", 8'h01, {7'h00, LOCKED});
        wr(6'h02, 8'h18);
        chk("unlocked", 8'h00, {7'h00, LOCKED});
        wr(6'h03, 8'h00);
        chk("drive_free", 8'h00, DRIVE_CFG);
        $display("test lock done");
        // Every timeout code; an access then clears the expiry
        for (int p = 0; p < 4; p++) begin
            wr(6'h03, 8'h20 | 8'(p << 3));
            n = 0;
            while (n < 200 && WD_EXPIRED !== 1'b1) begin
                @(posedge CLK);
                #1;
                n++;
            end
            ok = (n >= 19 + 10 * p) && (n <= 22 + 10 * p);
            chk("wd_cycles", 8'h01, {7'h00, ok});
            wr(6'h03, 8'h00);
            // Output flag trails the internal clear by one flop
            @(posedge CLK);
            #1;
            chk("wd_clear", 8'h00, {7'h00, WD_EXPIRED});
        end
        repeat (80) @(posedge CLK);
        #1;
        chk("wd_off", 8'h00, {7'h00, WD_EXPIRED});
        $display("test watchdog done");
        // Mid-run reset while locked and with the watchdog expired
        wr(6'h03, 8'h20);
        wr(6'h02, 8'h30);
        repeat (30) @(posedge CLK);
        #1;
        chk("wd_pre_rst", 8'h01, {7'h00, WD_EXPIRED});
        @(posedge CLK);
        RST <= 1'b1;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        #1;
        chk("rst_drive", 8'h07, DRIVE_CFG);
        chk("rst_ocmon", 8'h70, OCMON_CFG);
        chk("rst_chop", 8'h01, CHOP_CFG);
        chk("rst_mon_en", 8'h03, {6'h00, HIGH_MON_EN, LOW_MON_EN});
        chk("rst_lock", 8'h00, {7'h00, LOCKED});
        chk("rst_wd", 8'h00, {7'h00, WD_EXPIRED});
        wr(6'h03, 8'h1f);
        chk("rst_first_wr", 8'h1f, DRIVE_CFG);
        $display("test mid reset done");
        report_and_stop();
    end
endmodule : gate_driver_config_registers_tb
